// *** src/mac_config_regs.sv ***
// Configuration register group of the monitoring converter
`include "mac_map.svh"

// What this block does
// - Fixed-select 0: round delay is 1.42 ms times (8N+6), N from count register.
// - Fixed-select 1: round delay is a constant 728 ms, count ignored.
// - Disable bits 0-6 stop analog inputs, bit 7 temperature; errors suppressed.
// - A disabled analog input reads zero from the result store.
// - Temperature disabled: no temperature conversions, its result reads zero.
// - Pairing bits 0,2,4 make input pairs differential when set.
// - Polarity bits 1,3,5: set is normal, clear reverse; ignored when single-ended.
// - Rate field codes give seven rates; code 111 repeats 13.15 kHz.
// - Range field codes give full-scale ranges; 110 and 111 both 0.256 V.
// - Reset loads 40h, 00h, 00h and 02h into the four registers.
// - Count register at 0Bh supplies N; ignored while fixed-select is set.
module mac_config_regs #(
  parameter int unsigned RES_W        = 12,
  parameter int unsigned UNIT_CYCLES  = `MAC_UNIT_CYCLES,
  parameter int unsigned FIXED_CYCLES = `MAC_FIXED_CYCLES
) (
  input  wire logic                 i_clk,
  input  wire logic                 i_rst_n,
  input  wire logic                 i_wr,
  input  wire logic                 i_rd,
  input  wire logic [7:0]           i_addr,
  input  wire logic [7:0]           i_wdata,
  input  wire logic [7:0]           i_delay_count,
  input  wire logic [8*RES_W-1:0]   i_results,
  output logic      [7:0]           o_rdata,
  output logic                      o_rvalid,
  output logic      [7:0]           o_conv_enable,
  output logic      [7:0]           o_error_enable,
  output logic      [8*RES_W-1:0]   o_results,
  output mac_pkg::mac_cfg_s         o_cfg,
  output logic                      o_round_start
);

  // =====================================
  // Register storage
  logic [7:0]  delay_ctrl;
  logic [7:0]  chan_dis;
  logic [7:0]  pairing;
  logic [7:0]  conv_setup;
  logic [31:0] round_cnt;
  logic [31:0] next_target;
  logic        fixed_sel;

  // Reserved bits are stored as written; software keeps them zero
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      delay_ctrl <= `MAC_RST_DELAY_CTRL;
      chan_dis   <= `MAC_RST_CHAN_DIS;
      pairing    <= `MAC_RST_PAIRING;
      conv_setup <= `MAC_RST_CONV_SETUP;
    end else if (i_wr) begin
      unique case (i_addr)
        `MAC_OFS_DELAY_CTRL: delay_ctrl <= i_wdata;
        `MAC_OFS_CHAN_DIS:   chan_dis   <= i_wdata;
        `MAC_OFS_PAIRING:    pairing    <= i_wdata;
        `MAC_OFS_CONV_SETUP: conv_setup <= i_wdata;
        default: begin
        end
      endcase
    end
  end

  // =====================================
  // Read port
  // Count register storage lives elsewhere; its offset reads as zero here
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_rdata  <= 8'h00;
      o_rvalid <= 1'b0;
    end else begin
      o_rvalid <= i_rd;
      if (i_rd) begin
        unique case (i_addr)
          `MAC_OFS_DELAY_CTRL: o_rdata <= delay_ctrl;
          `MAC_OFS_CHAN_DIS:   o_rdata <= chan_dis;
          `MAC_OFS_PAIRING:    o_rdata <= pairing;
          `MAC_OFS_CONV_SETUP: o_rdata <= conv_setup;
          default:             o_rdata <= 8'h00;
        endcase
      end
    end
  end

  // =====================================
  // Monitoring round timer
  assign fixed_sel = delay_ctrl[`MAC_FIXED_DELAY_BIT];

  // Largest product is about 72.6 million cycles, well inside 32 bits
  always_comb begin
    if (fixed_sel) begin
      next_target = 32'(FIXED_CYCLES);
    end else begin
      next_target = 32'(UNIT_CYCLES) *
                    ((32'(i_delay_count) * `MAC_UNIT_MUL) + `MAC_UNIT_ADD);
    end
  end

  // Compare with >= so a shortened delay cannot let the counter run past
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      round_cnt     <= 32'h0000_0000;
      o_round_start <= 1'b0;
    end else if (round_cnt + 32'h1 >= next_target) begin
      round_cnt     <= 32'h0000_0000;
      o_round_start <= 1'b1;
    end else begin
      round_cnt     <= round_cnt + 32'h1;
      o_round_start <= 1'b0;
    end
  end

  // =====================================
  // Channel enables and result gating
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_conv_enable  <= 8'h00;
      o_error_enable <= 8'h00;
    end else begin
      o_conv_enable  <= ~chan_dis;
      o_error_enable <= ~chan_dis;
    end
  end

  generate
    for (genvar k = 0; k < 8; k++) begin : g_res
      always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
          o_results[k*RES_W +: RES_W] <= '0;
        end else if (chan_dis[k]) begin
          o_results[k*RES_W +: RES_W] <= '0;
        end else begin
          o_results[k*RES_W +: RES_W] <= i_results[k*RES_W +: RES_W];
        end
      end
    end
  endgenerate

  // =====================================
  // Pairing and converter setup decode
  // Code MSB sits in the lowest bit of each field
  logic [2:0] rate_code;
  logic [2:0] range_code;
  assign rate_code  = {conv_setup[`MAC_RATE_BIT_A], conv_setup[`MAC_RATE_BIT_B],
                       conv_setup[`MAC_RATE_BIT_C]};
  assign range_code = {conv_setup[`MAC_RANGE_BIT_A], conv_setup[`MAC_RANGE_BIT_B],
                       conv_setup[`MAC_RANGE_BIT_C]};

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_cfg <= '{diff: 3'h0, normal: 3'h0, reverse: 3'h0,
                 rate: mac_pkg::MAC_RATE_0K512, range: mac_pkg::MAC_RANGE_2V56};
    end else begin
      for (int p = 0; p < 3; p++) begin
        o_cfg.diff[p]    <= pairing[2*p];
        o_cfg.normal[p]  <= pairing[2*p] & pairing[2*p+1];
        o_cfg.reverse[p] <= pairing[2*p] & ~pairing[2*p+1];
      end
      // Code 111 is folded onto the fastest rate and the smallest range
      o_cfg.rate  <= (rate_code == 3'h7) ? mac_pkg::MAC_RATE_13K15 :
                     mac_pkg::mac_rate_e'(rate_code);
      o_cfg.range <= (range_code == 3'h7) ? mac_pkg::MAC_RANGE_0V256 :
                     mac_pkg::mac_range_e'(range_code);
    end
  end

  // =====================================
  // Checks
  reset_values_a: assert property (@(posedge i_clk)
    !i_rst_n |=> (delay_ctrl == 8'h40 && chan_dis == 8'h00 &&
                  pairing == 8'h00 && conv_setup == 8'h02))
    else $error("Reset values wrong");

  write_store_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_wr && i_addr == `MAC_OFS_CONV_SETUP |=> conv_setup == $past(i_wdata))
    else $error("Write not stored");

  read_back_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_wr && i_addr == `MAC_OFS_PAIRING ##1 i_rd && i_addr == `MAC_OFS_PAIRING
    |=> o_rvalid && o_rdata == $past(i_wdata, 2))
    else $error("Readback mismatch");

  fixed_round_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    fixed_sel && $stable(fixed_sel) && round_cnt == 32'(FIXED_CYCLES - 1) |=> o_round_start)
    else $error("Fixed round missed");

  prog_round_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !fixed_sel && o_round_start |-> $past(round_cnt) + 32'h1 >= $past(next_target))
    else $error("Programmable round early");

  chan_enable_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    chan_dis[3] ##1 chan_dis[3] |-> !o_conv_enable[3] && !o_error_enable[3])
    else $error("Disabled channel still enabled");

  analog_zero_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $past(chan_dis[0]) && $past(i_rst_n) |-> o_results[RES_W-1:0] == '0)
    else $error("Disabled input not zero");

  temp_zero_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $past(chan_dis[7]) && $past(i_rst_n) |-> o_results[8*RES_W-1 -: RES_W] == '0
      && !o_conv_enable[7])
    else $error("Temperature not suppressed");

  polarity_ignored_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $past(i_rst_n) && !$past(pairing[2]) |-> !o_cfg.diff[1] && !o_cfg.normal[1]
      && !o_cfg.reverse[1])
    else $error("Polarity used while single-ended");

  rate_fold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $past(i_rst_n) && $past(rate_code) == 3'h7 |-> o_cfg.rate == mac_pkg::MAC_RATE_13K15)
    else $error("Rate code 111 wrong");

  range_fold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $past(i_rst_n) && $past(range_code) == 3'h7 |-> o_cfg.range == mac_pkg::MAC_RANGE_0V256)
    else $error("Range code 111 wrong");

  // =====================================
  // Register write and read checks
  // Each check looks one edge back so a write or read during reset never counts
  delay_write_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $past(i_rst_n) && $past(i_wr) && $past(i_addr) == `MAC_OFS_DELAY_CTRL
    |-> delay_ctrl == $past(i_wdata))
    else $error("Delay control write not stored");

  chan_write_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $past(i_rst_n) && $past(i_wr) && $past(i_addr) == `MAC_OFS_CHAN_DIS
    |-> chan_dis == $past(i_wdata))
    else $error("Channel disable write not stored");

  pair_write_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $past(i_rst_n) && $past(i_wr) && $past(i_addr) == `MAC_OFS_PAIRING
    |-> pairing == $past(i_wdata))
    else $error("Pairing write not stored");

  delay_read_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $past(i_rst_n) && $past(i_rd) && $past(i_addr) == `MAC_OFS_DELAY_CTRL
    |-> o_rdata == $past(delay_ctrl))
    else $error("Delay control read wrong");

  chan_read_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $past(i_rst_n) && $past(i_rd) && $past(i_addr) == `MAC_OFS_CHAN_DIS
    |-> o_rdata == $past(chan_dis))
    else $error("Channel disable read wrong");

  pair_read_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $past(i_rst_n) && $past(i_rd) && $past(i_addr) == `MAC_OFS_PAIRING
    |-> o_rdata == $past(pairing))
    else $error("Pairing read wrong");

  setup_read_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $past(i_rst_n) && $past(i_rd) && $past(i_addr) == `MAC_OFS_CONV_SETUP
    |-> o_rdata == $past(conv_setup))
    else $error("Converter setup read wrong");

  count_read_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $past(i_rst_n) && $past(i_rd) && $past(i_addr) == `MAC_OFS_DELAY_COUNT
    |-> o_rdata == 8'h00)
    else $error("Count offset read not zero");

  read_valid_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $past(i_rst_n) |-> o_rvalid == $past(i_rd))
    else $error("Read valid pulse wrong");

  // =====================================
  // Channel and decode checks
  conv_enable_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $past(i_rst_n) |-> o_conv_enable == ~$past(chan_dis))
    else $error("Conversion enables wrong");

  error_enable_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $past(i_rst_n) |-> o_error_enable == ~$past(chan_dis))
    else $error("Error enables wrong");

  result_pass_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $past(i_rst_n) && !$past(chan_dis[1])
    |-> o_results[2*RES_W-1 -: RES_W] == $past(i_results[2*RES_W-1 -: RES_W]))
    else $error("Enabled input result lost");

  diff_map_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $past(i_rst_n) |-> o_cfg.diff == {$past(pairing[4]), $past(pairing[2]), $past(pairing[0])})
    else $error("Differential map wrong");

  pol_select_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $past(i_rst_n) && $past(pairing[0])
    |-> o_cfg.normal[0] == $past(pairing[1]) && o_cfg.reverse[0] == !$past(pairing[1]))
    else $error("Polarity select wrong");

  rate_pass_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $past(i_rst_n) && $past(rate_code) != 3'h7 |-> o_cfg.rate == $past(rate_code))
    else $error("Rate code wrong");

  range_pass_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $past(i_rst_n) && $past(range_code) != 3'h7 |-> o_cfg.range == $past(range_code))
    else $error("Range code wrong");

endmodule : mac_config_regs

// *** src/mac_map.svh ***
// Register offsets, field positions, reset values and timing figures of the config group
`ifndef MAC_MAP_SVH
`define MAC_MAP_SVH

// =====================================
// Offsets
`define MAC_OFS_DELAY_CTRL   8'h07
`define MAC_OFS_CHAN_DIS     8'h08
`define MAC_OFS_PAIRING      8'h09
`define MAC_OFS_CONV_SETUP   8'h0a
`define MAC_OFS_DELAY_COUNT  8'h0b

// =====================================
// Reset values
`define MAC_RST_DELAY_CTRL   8'h40
`define MAC_RST_CHAN_DIS     8'h00
`define MAC_RST_PAIRING      8'h00
`define MAC_RST_CONV_SETUP   8'h02

// =====================================
// Field positions
`define MAC_FIXED_DELAY_BIT  0
`define MAC_TEMP_DIS_BIT     7
`define MAC_RATE_BIT_A       0
`define MAC_RATE_BIT_B       1
`define MAC_RATE_BIT_C       2
`define MAC_RANGE_BIT_A      3
`define MAC_RANGE_BIT_B      4
`define MAC_RANGE_BIT_C      5

// =====================================
// Timing
`define MAC_CLK_KHZ          25000
`define MAC_UNIT_US          1420
`define MAC_FIXED_MS         728
`define MAC_UNIT_MUL         8
`define MAC_UNIT_ADD         6
`define MAC_UNIT_CYCLES      (`MAC_UNIT_US * `MAC_CLK_KHZ / 1000)
`define MAC_FIXED_CYCLES     (`MAC_FIXED_MS * `MAC_CLK_KHZ)

`endif

// *** src/mac_pkg.sv ***
// Types shared by the monitor converter config group
package mac_pkg;

  // =====================================
  // Sample rate selections
  typedef enum logic [2:0] {
    MAC_RATE_0K512 = 3'h0,
    MAC_RATE_1K    = 3'h1,
    MAC_RATE_1K98  = 3'h2,
    MAC_RATE_3K6   = 3'h3,
    MAC_RATE_6K3   = 3'h4,
    MAC_RATE_9K8   = 3'h5,
    MAC_RATE_13K15 = 3'h6
  } mac_rate_e;

  // =====================================
  // Full-scale range selections
  typedef enum logic [2:0] {
    MAC_RANGE_2V56   = 3'h0,
    MAC_RANGE_SUPPLY = 3'h1,
    MAC_RANGE_4V096  = 3'h2,
    MAC_RANGE_2V048  = 3'h3,
    MAC_RANGE_1V024  = 3'h4,
    MAC_RANGE_0V512  = 3'h5,
    MAC_RANGE_0V256  = 3'h6
  } mac_range_e;

  // =====================================
  // Decoded converter configuration
  typedef struct packed {
    logic [2:0] diff;
    logic [2:0] normal;
    logic [2:0] reverse;
    mac_rate_e  rate;
    mac_range_e range;
  } mac_cfg_s;

endpackage : mac_pkg

// *** verif/mac_config_regs_test.sv ***
// Self-checking bench for the monitor converter config group
`define MAC_CHK(got, exp) begin \
  n_checks++; \
  if ((got) !== (exp)) begin \
    n_errors++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp); \
  end \
end

module mac_config_regs_test;
  timeunit 1ns;
  timeprecision 1ps;

  // =====================================
  // Harness
  localparam int UNIT = 4;
  localparam int FIX  = 20;
  logic              i_clk         = 1'b0;
  logic              i_rst_n       = 1'b0;
  logic              i_wr          = 1'b0;
  logic              i_rd          = 1'b0;
  logic [7:0]        i_addr        = 8'h00;
  logic [7:0]        i_wdata       = 8'h00;
  logic [7:0]        i_delay_count = 8'h00;
  logic [95:0]       i_results     = '0;
  logic [7:0]        o_rdata;
  logic              o_rvalid;
  logic [7:0]        o_conv_enable;
  logic [7:0]        o_error_enable;
  logic [95:0]       o_results;
  mac_pkg::mac_cfg_s o_cfg;
  logic              o_round_start;
  int                n_errors      = 0;
  int                n_checks      = 0;
  int                cyc           = 0;
  int                per;

  mac_config_regs #(.RES_W(12), .UNIT_CYCLES(UNIT), .FIXED_CYCLES(FIX)) dut_u (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_wr(i_wr), .i_rd(i_rd), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_delay_count(i_delay_count), .i_results(i_results),
    .o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_conv_enable(o_conv_enable),
    .o_error_enable(o_error_enable), .o_results(o_results), .o_cfg(o_cfg),
    .o_round_start(o_round_start));

  always #20 i_clk = ~i_clk;

  // Hang guard, far above the longest expected run
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 4000) begin
      n_errors++;
      tally_and_finish();
    end
  end

  // =====================================
  // Bus tasks
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
    repeat (3) @(posedge i_clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    `MAC_CHK(o_rvalid, 1'b1)
    `MAC_CHK(o_rdata, exp)
  endtask : rd

  // Bounded wait; per ends as the edge count up to the pulse
  task automatic wait_pulse();
    per = 0;
    do begin
      @(posedge i_clk);
      #1;
      per++;
    end while (o_round_start !== 1'b1 && per < 300);
  endtask : wait_pulse

  // =====================================
  // Scenarios
  task automatic t_reset();
    rd(8'h07, 8'h40);
    rd(8'h08, 8'h00);
    rd(8'h09, 8'h00);
    rd(8'h0a, 8'h02);
    `MAC_CHK(o_cfg.rate, 3'h2)
    wr(8'h0b, 8'hff);
    rd(8'h0b, 8'h00);
  endtask : t_reset

  task automatic t_disable();
    logic [95:0] exp;
    for (int k = 0; k < 8; k++) i_results[k*12 +: 12] <= 12'h5a0 + 12'(k);
    wr(8'h08, 8'h8d);
    rd(8'h08, 8'h8d);
    exp = i_results;
    for (int k = 0; k < 8; k++) if (k == 0 || k == 2 || k == 3 || k == 7) exp[k*12 +: 12] = '0;
    `MAC_CHK(o_conv_enable, 8'h72)
    `MAC_CHK(o_error_enable, 8'h72)
    `MAC_CHK(o_results[83:0], exp[83:0])
    `MAC_CHK(o_results[95:84], 12'h000)
  endtask : t_disable

  task automatic t_pairing();
    // Pair b single-ended with its polarity set: both outputs must stay low
    wr(8'h09, 8'h0b);
    `MAC_CHK(o_cfg.diff, 3'b001)
    `MAC_CHK(o_cfg.normal, 3'b001)
    `MAC_CHK(o_cfg.reverse, 3'b000)
    // Write then read on the very next edge must see the new value
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= 8'h09;
    i_wdata <= 8'h15;
    @(posedge i_clk);
    i_wr <= 1'b0;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    `MAC_CHK(o_rdata, 8'h15)
    wr(8'h09, 8'h34);
    rd(8'h09, 8'h34);
    `MAC_CHK(o_cfg.diff, 3'b110)
    `MAC_CHK(o_cfg.normal, 3'b100)
    `MAC_CHK(o_cfg.reverse, 3'b010)
  endtask : t_pairing

  task automatic t_fields();
    logic [2:0] c;
    logic [2:0] e;
    for (int i = 0; i < 8; i++) begin
      c = 3'(i);
      e = (c == 3'h7) ? 3'h6 : c;
      wr(8'h0a, {2'b00, c[0], c[1], c[2], c[0], c[1], c[2]});
      `MAC_CHK(o_cfg.rate, e)
      `MAC_CHK(o_cfg.range, e)
    end
  endtask : t_fields

  task automatic t_timer();
    i_delay_count <= 8'h03;
    wr(8'h07, 8'h01);
    wait_pulse();
    wait_pulse();
    `MAC_CHK(per, FIX)
    i_delay_count <= 8'h00;
    wr(8'h07, 8'h00);
    wait_pulse();
    wait_pulse();
    `MAC_CHK(per, UNIT * 6)
    i_delay_count <= 8'h02;
    wait_pulse();
    wait_pulse();
    `MAC_CHK(per, UNIT * 22)
  endtask : t_timer

  // =====================================
  // Sequence and verdict
  task automatic tally_and_finish();
    $display("checks=%0d errors=%0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (3) @(posedge i_clk);
    i_rst_n <= 1'b1;
    t_reset();
    t_disable();
    t_pairing();
    t_fields();
    t_timer();
    tally_and_finish();
  end
endmodule : mac_config_regs_test
